// File: common/ict_timing_map.vh
// instruction cycle timing constants: table entries, field layout, counts
// assumes inclusion by bare name from the sequencer and its table module
`ifndef ICT_TIMING_MAP_VH
`define ICT_TIMING_MAP_VH

// ------------------------------------------------------------
// entry field layout {clocks, reads, writes, eaAdd, moveKind, moveLong}
// ------------------------------------------------------------
`define ICT_F_CLK_HI      19
`define ICT_F_CLK_LO      12
`define ICT_F_RD_HI       11
`define ICT_F_RD_LO       8
`define ICT_F_WR_HI       7
`define ICT_F_WR_LO       4
`define ICT_F_EA          3
`define ICT_F_MV_HI       2
`define ICT_F_MV_LO       1
`define ICT_F_LONG        0
`define ICT_ENTRY_W       20
`define ICT_MV_NONE       2'h0
`define ICT_MV_READ       2'h1
`define ICT_MV_WRITE      2'h2

// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define ICT_BUS_CYCLE_CLK 2'h3
`define ICT_PER_REG_WORD  10'h004
`define ICT_PER_REG_LONG  10'h008
`define ICT_PER_REG_XFER  7'h01
`define ICT_PER_REG_XFERL 7'h02

// ------------------------------------------------------------
// table selector codes for the loop instruction outcomes
// ------------------------------------------------------------
`define ICT_SEL_LOOP_TAKEN   5'h10
`define ICT_SEL_LOOP_EXPIRED 5'h11
`define ICT_SEL_LOOP_CCTRUE  5'h12

// ------------------------------------------------------------
// table entries: clocks, reads, writes, ea, move kind, long
// ------------------------------------------------------------
`define ICT_T_BIT_CHANGE_OP_DR  {8'h08, 4'h1, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_CHANGE_OP_DM  {8'h08, 4'h1, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BIT_CHANGE_OP_SR  {8'h0c, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_CHANGE_OP_SM  {8'h0c, 4'h2, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BIT_CLEAR_OP_DR  {8'h0a, 4'h1, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_CLEAR_OP_DM  {8'h08, 4'h1, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BIT_CLEAR_OP_SR  {8'h0e, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_CLEAR_OP_SM  {8'h0c, 4'h2, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BIT_SET_OP_DR  {8'h08, 4'h1, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_SET_OP_DM  {8'h08, 4'h1, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BIT_SET_OP_SR  {8'h0c, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BIT_SET_OP_SM  {8'h0c, 4'h2, 4'h1, 1'h1, 2'h0, 1'h0}
`define ICT_T_BTST_DR  {8'h06, 4'h1, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BTST_DM  {8'h04, 4'h1, 4'h0, 1'h1, 2'h0, 1'h0}
`define ICT_T_BTST_SR  {8'h0a, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_BTST_SM  {8'h08, 4'h2, 4'h0, 1'h1, 2'h0, 1'h0}
`define ICT_T_LOOP_TK  {8'h0a, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_LOOP_EX  {8'h0e, 4'h3, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_LOOP_CT  {8'h0c, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_XADD_MW  {8'h12, 4'h3, 4'h1, 1'h0, 2'h0, 1'h0}
`define ICT_T_XADD_ML  {8'h1e, 4'h5, 4'h2, 1'h0, 2'h0, 1'h0}
`define ICT_T_XSUB_MW  {8'h12, 4'h3, 4'h1, 1'h0, 2'h0, 1'h0}
`define ICT_T_XSUB_ML  {8'h1e, 4'h5, 4'h2, 1'h0, 2'h0, 1'h0}
`define ICT_T_MVMR_W   {8'h0c, 4'h3, 4'h0, 1'h0, 2'h1, 1'h0}
`define ICT_T_MVMR_L   {8'h0c, 4'h3, 4'h0, 1'h0, 2'h1, 1'h1}
`define ICT_T_MVRM_W   {8'h08, 4'h2, 4'h0, 1'h0, 2'h2, 1'h0}
`define ICT_T_MVRM_L   {8'h08, 4'h2, 4'h0, 1'h0, 2'h2, 1'h1}
`define ICT_T_CALL_IX  {8'h16, 4'h2, 4'h2, 1'h0, 2'h0, 1'h0}
`define ICT_T_LOAD_IX  {8'h0c, 4'h2, 4'h0, 1'h0, 2'h0, 1'h0}
`define ICT_T_PUSH_IX  {8'h14, 4'h2, 4'h2, 1'h0, 2'h0, 1'h0}
`define ICT_T_MVMR_IX  {8'h12, 4'h4, 4'h0, 1'h0, 2'h1, 1'h0}
`define ICT_T_NOP      {8'h04, 4'h1, 4'h0, 1'h0, 2'h0, 1'h0}

`endif

// File: core/ict_timing_rom.v
// timing table: one registered entry per instruction selector
// assumes the selector is stable on the clock it is sampled
`timescale 1ns/10ps
`default_nettype none
`include "ict_timing_map.vh"

module ict_timing_rom
(
  input  wire                    core_clk,  // core clock
  input  wire                    rst_n,     // sync reset, active low
  input  wire [4:0]              sel,       // instruction selector
  output reg  [`ICT_ENTRY_W-1:0] entry_q    // registered table entry
);

  // ------------------------------------------------------------
  // table lookup, read data from a register
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_n)
      entry_q <= {`ICT_ENTRY_W{1'b0}};
    else
    begin
      case (sel)
        // RL2 register forms at maximum
        5'h00:   entry_q <= `ICT_T_BIT_CHANGE_OP_DR;
        5'h01:   entry_q <= `ICT_T_BIT_CHANGE_OP_DM;
        5'h02:   entry_q <= `ICT_T_BIT_CHANGE_OP_SR;
        5'h03:   entry_q <= `ICT_T_BIT_CHANGE_OP_SM;
        5'h04:   entry_q <= `ICT_T_BIT_CLEAR_OP_DR;
        5'h05:   entry_q <= `ICT_T_BIT_CLEAR_OP_DM;
        5'h06:   entry_q <= `ICT_T_BIT_CLEAR_OP_SR;
        5'h07:   entry_q <= `ICT_T_BIT_CLEAR_OP_SM;
        5'h08:   entry_q <= `ICT_T_BIT_SET_OP_DR;
        5'h09:   entry_q <= `ICT_T_BIT_SET_OP_DM;
        5'h0a:   entry_q <= `ICT_T_BIT_SET_OP_SR;
        5'h0b:   entry_q <= `ICT_T_BIT_SET_OP_SM;
        5'h0c:   entry_q <= `ICT_T_BTST_DR;
        5'h0d:   entry_q <= `ICT_T_BTST_DM;
        5'h0e:   entry_q <= `ICT_T_BTST_SR;
        5'h0f:   entry_q <= `ICT_T_BTST_SM;
        5'h10:   entry_q <= `ICT_T_LOOP_TK;
        5'h11:   entry_q <= `ICT_T_LOOP_EX;
        5'h12:   entry_q <= `ICT_T_LOOP_CT;
        5'h13:   entry_q <= `ICT_T_XADD_MW;
        5'h14:   entry_q <= `ICT_T_XADD_ML;
        5'h15:   entry_q <= `ICT_T_XSUB_MW;
        5'h16:   entry_q <= `ICT_T_XSUB_ML;
        5'h17:   entry_q <= `ICT_T_MVMR_W;
        5'h18:   entry_q <= `ICT_T_MVMR_L;
        5'h19:   entry_q <= `ICT_T_MVRM_W;
        5'h1a:   entry_q <= `ICT_T_MVRM_L;
        5'h1b:   entry_q <= `ICT_T_CALL_IX;
        5'h1c:   entry_q <= `ICT_T_LOAD_IX;
        5'h1d:   entry_q <= `ICT_T_PUSH_IX;
        5'h1e:   entry_q <= `ICT_T_MVMR_IX;
        default: entry_q <= `ICT_T_NOP;
      endcase
    end
  end

endmodule // ict_timing_rom
`default_nettype wire

// File: core/ict_sequencer.v
// instruction cycle sequencer: plays out clocks and bus cycles per instruction
// assumes zero-wait bus cycles of four clocks and a same-clock start pulse
//
// Summary of operation
// RL1 - add address-calculation cost where entry flags it
// RL2 - register bit change/clear/set use maximum counts
// RL3 - loop taken: 10 clocks, two reads
// RL4 - loop falls through: 14(3/0) or 12(2/0)
// RL5 - multi-register move adds 4n/8n, per-register transfers
// RL6 - index register size never changes timing
// RL7 - extended add/subtract memory: 18(3/1), 30(5/2)
// RL8 - each figure: clocks, reads, writes
// RL9 - spare clocks become internal idle cycles
`timescale 1ns/10ps
`default_nettype none
`include "ict_timing_map.vh"

module ict_sequencer
(
  input  wire       core_clk,      // 20 MHz core clock
  input  wire       rst_n,         // sync reset, active low
  input  wire       start,         // one-cycle request, taken when idle
  input  wire [4:0] instrSel,      // instruction selector
  input  wire       loopCondTrue,  // loop condition true
  input  wire       loopExpired,   // loop counter expired
  input  wire       indexLong,     // index register used as long word
  input  wire [7:0] eaClocks,      // address calculation clocks
  input  wire [3:0] eaReads,       // address calculation reads
  input  wire [3:0] eaWrites,      // address calculation writes
  input  wire [4:0] regCount,      // registers moved (0..16)
  output reg        busy_q,        // instruction in progress
  output reg        done_q,        // pulse on last clock
  output reg        busRead_q,     // pulse at start of each read cycle
  output reg        busWrite_q,    // pulse at start of each write cycle
  output reg        idleCycle_q,   // internal idle clock
  output reg  [9:0] totalClk_q,    // total clocks of current instruction
  output reg  [6:0] totalRd_q,     // total reads
  output reg  [6:0] totalWr_q      // total writes
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;  // waiting for start
  localparam [1:0] ST_LOOK = 2'h1;  // table read in flight
  localparam [1:0] ST_SUM  = 2'h2;  // totals formed
  localparam [1:0] ST_RUN  = 2'h3;  // clocks playing out

  reg  [1:0]              state_q;     // sequencer state
  reg  [1:0]              state_d;
  reg  [4:0]              sel_q;       // latched table selector
  reg  [4:0]              sel_d;
  reg  [7:0]              eaClk_q;     // latched overhead clocks
  reg  [3:0]              eaRd_q;      // latched overhead reads
  reg  [3:0]              eaWr_q;      // latched overhead writes
  reg  [4:0]              nReg_q;      // latched register count
  reg  [9:0]              clkLeft_q;   // clocks still to run
  reg  [9:0]              clkLeft_d;
  reg  [6:0]              rdLeft_q;    // reads still to issue
  reg  [6:0]              rdLeft_d;
  reg  [6:0]              wrLeft_q;    // writes still to issue
  reg  [6:0]              wrLeft_d;
  reg  [1:0]              phase_q;     // clock within a bus cycle
  reg  [1:0]              phase_d;
  reg                     busAct_q;    // bus cycle in progress
  reg                     busAct_d;
  reg                     busy_d;
  reg                     done_d;
  reg                     busRead_d;
  reg                     busWrite_d;
  reg                     idleCycle_d;
  reg  [9:0]              sumClk;      // combined clock total
  reg  [6:0]              sumRd;       // combined read total
  reg  [6:0]              sumWr;       // combined write total
  reg  [9:0]              perClk;      // clocks per moved register
  reg  [6:0]              perXfer;     // transfers per moved register
  wire [`ICT_ENTRY_W-1:0] entry;       // table entry

  // ------------------------------------------------------------
  // timing table
  // ------------------------------------------------------------
  ict_timing_rom u_rom
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sel      (sel_q),
    .entry_q  (entry)
  );

  // ------------------------------------------------------------
  // selector remap for the loop instruction outcomes
  // ------------------------------------------------------------
  always @*
  begin
    sel_d = instrSel;
    if (instrSel == `ICT_SEL_LOOP_TAKEN || instrSel == `ICT_SEL_LOOP_EXPIRED ||
        instrSel == `ICT_SEL_LOOP_CCTRUE)
    begin
      // RL4 fall-through cases
      if (loopCondTrue)
        sel_d = `ICT_SEL_LOOP_CCTRUE;
      else if (loopExpired)
        sel_d = `ICT_SEL_LOOP_EXPIRED;
      else
        // RL3 branch taken case
        sel_d = `ICT_SEL_LOOP_TAKEN;
    end
  end

  // ------------------------------------------------------------
  // totals from table entry, overhead and register count
  // ------------------------------------------------------------
  always @*
  begin
    // RL5 per-register cost by size
    perClk  = entry[`ICT_F_LONG] ? `ICT_PER_REG_LONG : `ICT_PER_REG_WORD;
    perXfer = entry[`ICT_F_LONG] ? `ICT_PER_REG_XFERL : `ICT_PER_REG_XFER;
    // RL8 clocks, reads, writes per entry
    sumClk  = {2'h0, entry[`ICT_F_CLK_HI:`ICT_F_CLK_LO]};
    sumRd   = {3'h0, entry[`ICT_F_RD_HI:`ICT_F_RD_LO]};
    sumWr   = {3'h0, entry[`ICT_F_WR_HI:`ICT_F_WR_LO]};
    // RL1 address calculation overhead
    if (entry[`ICT_F_EA])
    begin
      sumClk = sumClk + {2'h0, eaClk_q};
      sumRd  = sumRd + {3'h0, eaRd_q};
      sumWr  = sumWr + {3'h0, eaWr_q};
    end
    // RL5 register transfers in the move direction
    if (entry[`ICT_F_MV_HI:`ICT_F_MV_LO] != `ICT_MV_NONE)
      sumClk = sumClk + perClk * {5'h00, nReg_q};
    if (entry[`ICT_F_MV_HI:`ICT_F_MV_LO] == `ICT_MV_READ)
      sumRd = sumRd + perXfer * {2'h0, nReg_q};
    if (entry[`ICT_F_MV_HI:`ICT_F_MV_LO] == `ICT_MV_WRITE)
      sumWr = sumWr + perXfer * {2'h0, nReg_q};
  end

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always @*
  begin
    state_d     = state_q;
    clkLeft_d   = clkLeft_q;
    rdLeft_d    = rdLeft_q;
    wrLeft_d    = wrLeft_q;
    phase_d     = phase_q;
    busAct_d    = busAct_q;
    busy_d      = busy_q;
    done_d      = 1'b0;
    busRead_d   = 1'b0;
    busWrite_d  = 1'b0;
    idleCycle_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        // start taken only when idle
        if (start)
        begin
          state_d = ST_LOOK;
          busy_d  = 1'b1;
        end
      end
      ST_LOOK:
        state_d = ST_SUM;
      ST_SUM:
      begin
        // load the counters from the totals
        clkLeft_d = sumClk;
        rdLeft_d  = sumRd;
        wrLeft_d  = sumWr;
        busAct_d  = 1'b0;
        phase_d   = 2'h0;
        state_d   = ST_RUN;
      end
      ST_RUN:
      begin
        clkLeft_d = clkLeft_q - 10'h001;
        if (!busAct_q || phase_q == `ICT_BUS_CYCLE_CLK)
        begin
          phase_d = 2'h0;
          if (rdLeft_q != 7'h00)
          begin
            // reads first
            busAct_d  = 1'b1;
            busRead_d = 1'b1;
            rdLeft_d  = rdLeft_q - 7'h01;
          end
          else if (wrLeft_q != 7'h00)
          begin
            busAct_d   = 1'b1;
            busWrite_d = 1'b1;
            wrLeft_d   = wrLeft_q - 7'h01;
          end
          else
          begin
            // RL9 spare clock is internal
            busAct_d    = 1'b0;
            idleCycle_d = 1'b1;
          end
        end
        else
          phase_d = phase_q + 2'h1;
        // last clock ends the instruction
        if (clkLeft_q <= 10'h001)
        begin
          done_d  = 1'b1;
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      sel_q       <= 5'h00;
      eaClk_q     <= 8'h00;
      eaRd_q      <= 4'h0;
      eaWr_q      <= 4'h0;
      nReg_q      <= 5'h00;
      clkLeft_q   <= 10'h000;
      rdLeft_q    <= 7'h00;
      wrLeft_q    <= 7'h00;
      phase_q     <= 2'h0;
      busAct_q    <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      busRead_q   <= 1'b0;
      busWrite_q  <= 1'b0;
      idleCycle_q <= 1'b0;
      totalClk_q  <= 10'h000;
      totalRd_q   <= 7'h00;
      totalWr_q   <= 7'h00;
    end
    else
    begin
      state_q     <= state_d;
      clkLeft_q   <= clkLeft_d;
      rdLeft_q    <= rdLeft_d;
      wrLeft_q    <= wrLeft_d;
      phase_q     <= phase_d;
      busAct_q    <= busAct_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      busRead_q   <= busRead_d;
      busWrite_q  <= busWrite_d;
      idleCycle_q <= idleCycle_d;
      if (state_q == ST_IDLE && start)
      begin
        // RL6 index size is not an input to timing
        sel_q   <= sel_d;
        eaClk_q <= eaClocks;
        eaRd_q  <= eaReads;
        eaWr_q  <= eaWrites;
        nReg_q  <= regCount;
      end
      if (state_q == ST_SUM)
      begin
        // RL7 extended add/subtract totals reported
        totalClk_q <= sumClk;
        totalRd_q  <= sumRd;
        totalWr_q  <= sumWr;
      end
    end
  end

  // RL2 register forms take the maximum count from the table
  // RL6 indexLong is deliberately unused in every path
  wire unusedIndex = indexLong;

endmodule // ict_sequencer
`default_nettype wire

// File: bench/ict_sequencer_sva.sv
// checker for the cycle sequencer: strobe order, bus cycle length, totals
// assumes a bind onto ict_sequencer with its port names unchanged
`timescale 1ns/10ps
`default_nettype none

module ict_sequencer_sva
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       start,
  input wire logic [4:0] instrSel,
  input wire logic       loopCondTrue,
  input wire logic       loopExpired,
  input wire logic       indexLong,
  input wire logic [7:0] eaClocks,
  input wire logic [3:0] eaReads,
  input wire logic [3:0] eaWrites,
  input wire logic [4:0] regCount,
  input wire logic       busy_q,
  input wire logic       done_q,
  input wire logic       busRead_q,
  input wire logic       busWrite_q,
  input wire logic       idleCycle_q,
  input wire logic [9:0] totalClk_q,
  input wire logic [6:0] totalRd_q,
  input wire logic [6:0] totalWr_q
);
  logic [6:0] rdCnt_q;    // reads since last done
  logic [6:0] wrCnt_q;    // writes since last done
  logic [9:0] idleCnt_q;  // idle clocks since last done
  logic       wrSeen_q;   // a write already issued

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // tallies clear on done; the done cycle's own strobe joins at the check
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || done_q)
    begin
      rdCnt_q   <= 7'h00;
      wrCnt_q   <= 7'h00;
      idleCnt_q <= 10'h000;
      wrSeen_q  <= 1'b0;
    end
    else
    begin
      rdCnt_q   <= rdCnt_q + 7'(busRead_q);
      wrCnt_q   <= wrCnt_q + 7'(busWrite_q);
      idleCnt_q <= idleCnt_q + 10'(idleCycle_q);
      wrSeen_q  <= wrSeen_q | busWrite_q;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  AST_DONE_PULSE: assert property (done_q |-> (!busy_q && $past(busy_q)) ##1 !done_q)
    else $error("done is not a single pulse closing busy");
  AST_START_TAKEN: assert property (start && !busy_q |=> busy_q)
    else $error("start in idle was not taken");
  AST_QUIET_IDLE: assert property (!busy_q && !done_q |-> !(busRead_q || busWrite_q || idleCycle_q))
    else $error("strobe outside an instruction");
  AST_ONE_KIND: assert property ($onehot0({busRead_q, busWrite_q, idleCycle_q}))
    else $error("two strobe kinds in one clock");
  AST_BUS_CYCLE_LEN: assert property (busRead_q || busWrite_q |=> (!busRead_q && !busWrite_q && !idleCycle_q)[*3])
    else $error("bus cycle shorter than four clocks");
  AST_READS_FIRST: assert property (busRead_q |-> !wrSeen_q)
    else $error("read after a write in one instruction");
  AST_CLOCK_SUM: assert property (done_q |-> totalClk_q == ((10'(rdCnt_q) + 10'(wrCnt_q)
    + 10'(busRead_q) + 10'(busWrite_q)) << 2) + idleCnt_q + 10'(idleCycle_q))
    else $error("bus and idle clocks do not fill the total");
  AST_RW_SUM: assert property (done_q |-> totalRd_q == rdCnt_q + 7'(busRead_q)
    && totalWr_q == wrCnt_q + 7'(busWrite_q))
    else $error("bus cycle count differs from totals");
  AST_TOTALS_HOLD: assert property (busy_q && $past(busy_q, 3) |-> $stable(totalClk_q)
    && $stable(totalRd_q) && $stable(totalWr_q))
    else $error("totals changed during an instruction");
endmodule // ict_sequencer_sva
`default_nettype wire

// File: bench/ict_bus_model.sv
// far side of the system bus: zero-wait memory tallying each instruction
// assumes one strobe per four-clock bus cycle and a done pulse per run
`timescale 1ns/10ps
`default_nettype none

module ict_bus_model
(
  input  wire logic        core_clk,    // core clock
  input  wire logic        rst_n,       // sync reset
  input  wire logic        rdStrobe,    // read cycle begins
  input  wire logic        wrStrobe,    // write cycle begins
  input  wire logic        idleStrobe,  // bus left idle
  input  wire logic        doneStrobe,  // instruction ends
  output var  logic [7:0]  rdSeen_q,    // reads of last instruction
  output var  logic [7:0]  wrSeen_q,    // writes of last instruction
  output var  logic [11:0] idleSeen_q   // idle clocks of last instruction
);
  logic [7:0]  rdRun_q;    // reads so far
  logic [7:0]  wrRun_q;    // writes so far
  logic [11:0] idleRun_q;  // idle clocks so far

  // memory answers with no wait; only the tally is kept
  always @(posedge core_clk)
  begin
    if (!rst_n || doneStrobe)
    begin
      rdRun_q   <= 8'h00;
      wrRun_q   <= 8'h00;
      idleRun_q <= 12'h000;
    end
    else
    begin
      rdRun_q   <= rdRun_q + {7'h00, rdStrobe};
      wrRun_q   <= wrRun_q + {7'h00, wrStrobe};
      idleRun_q <= idleRun_q + {11'h000, idleStrobe};
    end
    // latch the finished instruction, done cycle included
    if (!rst_n)
      {rdSeen_q, wrSeen_q, idleSeen_q} <= 28'h0000000;
    else if (doneStrobe)
    begin
      rdSeen_q   <= rdRun_q + {7'h00, rdStrobe};
      wrSeen_q   <= wrRun_q + {7'h00, wrStrobe};
      idleSeen_q <= idleRun_q + {11'h000, idleStrobe};
    end
  end
endmodule // ict_bus_model
`default_nettype wire

// File: bench/ict_sequencer_bench.sv
// self-checking bench for the instruction cycle sequencer
// assumes the sequencer, bus model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none

bind ict_sequencer ict_sequencer_sva u_sva
(
  .core_clk(core_clk), .rst_n(rst_n), .start(start), .instrSel(instrSel),
  .loopCondTrue(loopCondTrue), .loopExpired(loopExpired), .indexLong(indexLong),
  .eaClocks(eaClocks), .eaReads(eaReads), .eaWrites(eaWrites), .regCount(regCount),
  .busy_q(busy_q), .done_q(done_q), .busRead_q(busRead_q), .busWrite_q(busWrite_q),
  .idleCycle_q(idleCycle_q), .totalClk_q(totalClk_q), .totalRd_q(totalRd_q),
  .totalWr_q(totalWr_q)
);

module ict_sequencer_bench;
  // row: selector, {condTrue, expired, indexLong}, overhead clk/rd/wr, n, clk, rd, wr
  typedef struct packed {logic [7:0] sel; logic [3:0] flg; logic [7:0] eaC;
    logic [3:0] eaR; logic [3:0] eaW; logic [7:0] n; logic [11:0] clk;
    logic [7:0] rd; logic [7:0] wr;} ict_row_t;
  localparam int NROWS = 40;
  ict_row_t rows [0:NROWS-1] = '{
    // bit ops with overhead driven on register forms too, counted on memory forms only, then loop outcomes and extended add/subtract
    64'h00_0_04_1_0_00_008_01_00, 64'h01_0_04_1_0_00_00c_02_01, 64'h02_0_06_1_0_00_00c_02_00,
    64'h03_0_0a_2_0_00_016_04_01, 64'h04_0_04_1_0_00_00a_01_00, 64'h05_0_06_1_0_00_00e_02_01,
    64'h06_0_00_0_0_00_00e_02_00, 64'h07_0_08_2_0_00_014_04_01, 64'h08_0_08_2_0_00_008_01_00,
    64'h09_0_08_1_1_00_010_02_02, 64'h0a_0_00_0_0_00_00c_02_00, 64'h0b_0_0c_3_0_00_018_05_01,
    64'h0c_0_04_1_0_00_006_01_00, 64'h0d_0_04_1_0_00_008_02_00, 64'h0e_0_00_0_0_00_00a_02_00,
    64'h0f_0_04_1_0_00_00c_03_00,
    64'h10_0_04_1_0_00_00a_02_00, 64'h11_2_00_0_0_00_00e_03_00, 64'h12_4_00_0_0_00_00c_02_00,
    64'h10_6_00_0_0_00_00c_02_00,
    64'h13_0_04_1_0_00_012_03_01, 64'h14_0_00_0_0_00_01e_05_02, 64'h15_0_00_0_0_00_012_03_01,
    64'h16_0_00_0_0_00_01e_05_02,
    // multi-register moves, n from 0 up to 16
    64'h17_0_00_0_0_00_00c_03_00, 64'h17_0_00_0_0_03_018_06_00, 64'h17_0_00_0_0_10_04c_13_00,
    64'h18_0_00_0_0_02_01c_07_00, 64'h18_0_00_0_0_10_08c_23_00, 64'h19_0_00_0_0_05_01c_02_05,
    64'h1a_0_00_0_0_10_088_02_20,
    // indexed forms, index word and long, then the unused selector
    64'h1b_0_00_0_0_00_016_02_02, 64'h1b_1_00_0_0_00_016_02_02, 64'h1c_0_00_0_0_00_00c_02_00,
    64'h1c_1_00_0_0_00_00c_02_00, 64'h1d_0_00_0_0_00_014_02_02, 64'h1d_1_00_0_0_00_014_02_02,
    64'h1e_0_00_0_0_01_016_05_00, 64'h1e_1_00_0_0_10_052_14_00, 64'h1f_0_04_1_0_00_004_01_00};

  logic        core_clk = 1'b0;   // 20 MHz clock
  logic        rst_n = 1'b0;      // sync reset
  logic        start = 1'b0;      // request pulse
  logic [4:0]  instrSel = 5'h00;  // selector
  logic        loopCondTrue = 1'b0;
  logic        loopExpired = 1'b0;
  logic        indexLong = 1'b0;
  logic [7:0]  eaClocks = 8'h00;
  logic [3:0]  eaReads = 4'h0;
  logic [3:0]  eaWrites = 4'h0;
  logic [4:0]  regCount = 5'h00;
  wire         busy_q, done_q, busRead_q, busWrite_q, idleCycle_q;
  wire  [9:0]  totalClk_q;
  wire  [6:0]  totalRd_q, totalWr_q;
  wire  [7:0]  rdSeen, wrSeen;    // far-side tallies
  wire  [11:0] idleSeen;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;

  ict_sequencer dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .start(start), .instrSel(instrSel),
    .loopCondTrue(loopCondTrue), .loopExpired(loopExpired), .indexLong(indexLong),
    .eaClocks(eaClocks), .eaReads(eaReads), .eaWrites(eaWrites), .regCount(regCount),
    .busy_q(busy_q), .done_q(done_q), .busRead_q(busRead_q), .busWrite_q(busWrite_q),
    .idleCycle_q(idleCycle_q), .totalClk_q(totalClk_q), .totalRd_q(totalRd_q),
    .totalWr_q(totalWr_q)
  );
  ict_bus_model farSide
  (
    .core_clk(core_clk), .rst_n(rst_n), .rdStrobe(busRead_q), .wrStrobe(busWrite_q),
    .idleStrobe(idleCycle_q), .doneStrobe(done_q), .rdSeen_q(rdSeen), .wrSeen_q(wrSeen),
    .idleSeen_q(idleSeen)
  );

  always #25 core_clk = ~core_clk;

  task automatic conclude();
    $display("counts: checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far above the roughly 1400 cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      $display("mismatch runCycles expected done seen %0d", cycles);
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [11:0] expV, input logic [11:0] gotV);
    checked++;
    if (gotV !== expV)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, expV, gotV);
    end
  endtask

  task automatic quietChk();
    chk("quietFlags", 12'h000, {busy_q, done_q, busRead_q, busWrite_q, idleCycle_q, totalRd_q});
    chk("quietClk", 12'h000, {2'h0, totalClk_q});
    chk("quietWr", 12'h000, {5'h00, totalWr_q});
  endtask

  // one start pulse driven at a rising edge, operands held afterwards
  task automatic launch(input ict_row_t r);
    @(posedge core_clk);
    instrSel <= r.sel[4:0];
    {loopCondTrue, loopExpired, indexLong} <= r.flg[2:0];
    eaClocks <= r.eaC;
    eaReads <= r.eaR;
    eaWrites <= r.eaW;
    regCount <= r.n[4:0];
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
  endtask

  task automatic waitDone();
    int k;
    k = 0;
    while (done_q !== 1'b1 && k < 400)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("doneSeen", 12'h001, {11'h000, done_q});
  endtask

  task automatic finishOp(input ict_row_t r);
    waitDone();
    @(posedge core_clk);
    #1;
    chk("totalClk", r.clk, {2'h0, totalClk_q});
    chk("totalRd", {4'h0, r.rd}, {5'h00, totalRd_q});
    chk("totalWr", {4'h0, r.wr}, {5'h00, totalWr_q});
    chk("busReads", {4'h0, r.rd}, {4'h0, rdSeen});
    chk("busWrites", {4'h0, r.wr}, {4'h0, wrSeen});
    chk("idleClocks", r.clk - {2'h0, r.rd + r.wr, 2'h0}, idleSeen);
  endtask

  task automatic runOp(input ict_row_t r);
    launch(r);
    finishOp(r);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    quietChk();
    $display("test reset done");
    for (int i = 0; i < NROWS; i++)
    begin
      runOp(rows[i]);
      $display("test row %0d done", i);
    end
    // next start lands in the done cycle of a 12-clock run
    launch(rows[1]);
    repeat (12) @(posedge core_clk);
    #1;
    chk("doneEarly", 12'h000, {11'h000, done_q});
    @(posedge core_clk);
    runOp(rows[39]);
    $display("test back-to-back done");
    launch(rows[30]);
    repeat (5) @(posedge core_clk);
    start <= 1'b1;
    instrSel <= 5'h1f;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    finishOp(rows[30]);
    $display("test refused start done");
    // reset in mid-run, then a fresh instruction
    launch(rows[30]);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    quietChk();
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    runOp(rows[39]);
    $display("test mid-run reset done");
    conclude();
  end
endmodule // ict_sequencer_bench
`default_nettype wire
